// [src/fch_top.sv]
// fast read, fast initiated inventory and fast initiate command handling
// assumes a frame decoder giving bytes between sof and eof pulses, and a
// response coder taking bytes at double rate; registers over avalon-mm
//
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "fch_map.svh"
module fch_top import fch_pkg::*; #(
	// arbitrary neutral maker code
	parameter logic [7:0] MFG_CODE = 8'hA5,
	parameter int T1_CYC = (`FCH_T1_NS * `FCH_CLK_MHZ + 999) / 1000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rx_sof_i,
	input wire logic rx_valid_i,
	input wire fch_byte_t rx_byte_i,
	input wire logic rx_eof_i,
	input wire logic tx_ready_i,
	output logic tx_valid_o,
	output fch_byte_t tx_byte_o,
	output logic tx_last_o,
	output logic tx_active_o,
	output logic tx_fast_o,
	output logic tx_high_rate_o,
	output logic tx_dual_sub_o,
	input wire logic [8:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	fch_state_t st_q;
	fch_byte_t rxb_q [`FCH_RXD_N];
	logic [4:0] cnt_q;
	logic new_q;
	logic [15:0] rx_crc;
	logic crc_ok;
	logic init_q;
	logic [63:0] uid_q;
	logic [63:0] lock_q;
	logic [31:0] mem_q [`FCH_NBLK_N];
	fch_byte_t afi_q;
	logic [15:0] crcerr_q;
	fch_byte_t lastcmd_q;
	logic [3:0] slot_q;
	logic live_q;
	logic [16:0] t1_q;
	logic start_q;
	logic [79:0] pay_q;
	logic [3:0] plen_q;
	logic tx_done;
	logic rx_take;

	////////////////////////////////////////////////////////////////////
	// request capture
	assign rx_take = rx_valid_i && (st_q == ST_RX) && (cnt_q != `FCH_RXD);
	assign crc_ok = (rx_crc == `FCH_CRC_RES);

	fch_crc u_rx_crc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(rx_sof_i && (st_q == ST_RX)),
		.en_i(rx_take),
		.byte_i(rx_byte_i),
		.crc_o(rx_crc),
		.nxt_o()
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 5'h00;
		end else if (rx_sof_i && (st_q == ST_RX)) begin
			cnt_q <= 5'h00;
		end else if (rx_take) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < `FCH_RXD_N; i++) begin
				rxb_q[i] <= 8'h00;
			end
		end else if (rx_take) begin
			rxb_q[cnt_q[3:0]] <= rx_byte_i;
		end
	end

	// new_q tells a fresh frame from a bare slot eof
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			new_q <= 1'b0;
		end else if (rx_sof_i && (st_q == ST_RX)) begin
			new_q <= 1'b1;
		end else if (st_q == ST_EVAL) begin
			new_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// request decode
	fch_byte_t fl, cmd, blk;
	logic [63:0] ruid, rmask, lmask;
	logic [3:0] mpos, mb, nib, slot_use;
	fch_byte_t mlen;
	logic [31:0] word_d;
	logic lock_d, afi_f, mism, inv_ok_d, rsp_d, seti_d, rd_ok_d;
	logic [79:0] pay_d;
	logic [3:0] plen_d;

	assign fl = rxb_q[`FCH_POS_FLG];
	assign cmd = rxb_q[`FCH_POS_CMD];
	assign afi_f = fl[`FCH_FLG_AFI];
	assign mpos = afi_f ? (`FCH_POS_MASK + 4'h1) : `FCH_POS_MASK;
	assign mlen = rxb_q[afi_f ? (`FCH_POS_MLEN + 4'h1) : `FCH_POS_MLEN];
	assign mb = 4'((mlen + 8'h07) >> 3);
	assign lmask = ~(64'hFFFF_FFFF_FFFF_FFFF << mlen[6:0]);
	assign nib = 4'(uid_q >> mlen[6:0]);
	assign slot_use = new_q ? 4'h0 : (slot_q + 4'h1);
	assign mism = fl[`FCH_FLG_ADR] && (ruid != uid_q);
	assign blk = rxb_q[fl[`FCH_FLG_ADR] ? `FCH_POS_BLK_ADR : `FCH_POS_BLK];
	assign word_d = mem_q[blk[5:0]];
	assign lock_d = lock_q[blk[5:0]];

	for (genvar k = 0; k < 8; k++) begin : g_fld
		assign ruid[8*k +: 8] = rxb_q[4'(`FCH_POS_UID + k)];
		assign rmask[8*k +: 8] = rxb_q[4'(mpos + 4'(k))];
	end

	always_comb begin
		rsp_d = 1'b0;
		seti_d = 1'b0;
		inv_ok_d = 1'b0;
		rd_ok_d = 1'b0;
		pay_d = '0;
		plen_d = 4'h0;
		// bad crc, short frame or foreign maker code: drop silently
		if (new_q && crc_ok && (cnt_q >= `FCH_LEN_MIN) &&
			(rxb_q[`FCH_POS_MFG] == MFG_CODE)) begin
			case (cmd)
				`FCH_CMD_READ: begin
					if (fl[`FCH_FLG_INV]) begin
						rsp_d = 1'b1;
						pay_d[15:0] = {`FCH_ERR_GEN, `FCH_RSP_ERR};
						plen_d = `FCH_PL_ERR;
					end else if (!fl[`FCH_FLG_SEL] && !mism) begin
						rsp_d = 1'b1;
						if (cnt_q != (fl[`FCH_FLG_ADR] ? `FCH_LEN_RD_ADR :
							`FCH_LEN_RD)) begin
							pay_d[15:0] = {`FCH_ERR_GEN, `FCH_RSP_ERR};
							plen_d = `FCH_PL_ERR;
						end else if (blk >= `FCH_NBLK) begin
							pay_d[15:0] = {`FCH_ERR_ADDR, `FCH_RSP_ERR};
							plen_d = `FCH_PL_ERR;
						end else if (fl[`FCH_FLG_OPT]) begin
							rd_ok_d = 1'b1;
							pay_d[47:0] = {word_d, 7'h00, lock_d,
								`FCH_RSP_OK};
							plen_d = `FCH_PL_RD_LK;
						end else begin
							rd_ok_d = 1'b1;
							pay_d[39:0] = {word_d, `FCH_RSP_OK};
							plen_d = `FCH_PL_RD;
						end
					end
				end
				`FCH_CMD_INIT: begin
					if (!fl[`FCH_FLG_INV] && !fl[`FCH_FLG_SEL] &&
						!fl[`FCH_FLG_ADR] && (cnt_q == `FCH_LEN_MIN)) begin
						rsp_d = 1'b1;
						seti_d = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		if ((new_q || live_q) && init_q && fl[`FCH_FLG_INV] &&
			(cmd == `FCH_CMD_INV) && (mlen <= `FCH_MASK_MAX) &&
			(cnt_q == `FCH_LEN_INV + {4'h0, afi_f} + {1'b0, mb}) &&
			(!afi_f || (rxb_q[`FCH_POS_AFI] == afi_q)) &&
			(!new_q || (crc_ok && (rxb_q[`FCH_POS_MFG] == MFG_CODE)))) begin
			inv_ok_d = 1'b1;
			if ((((uid_q ^ rmask) & lmask) == 64'h0000_0000_0000_0000) &&
				(fl[`FCH_FLG_ONE] || (nib == slot_use))) begin
				rsp_d = 1'b1;
			end
		end
		if (seti_d || (rsp_d && inv_ok_d)) begin
			pay_d = {uid_q, `FCH_DSFID, `FCH_RSP_OK};
			plen_d = `FCH_PL_UID;
		end
	end

	////////////////////////////////////////////////////////////////////
	// sequencing: eval, t1 wait, send
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= ST_RX;
			t1_q <= 17'h0_0000;
			start_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			case (st_q)
				ST_RX: begin
					if (rx_eof_i) begin
						st_q <= ST_EVAL;
					end
				end
				ST_EVAL: begin
					if (rsp_d) begin
						st_q <= ST_WAIT;
						t1_q <= 17'(T1_CYC - 1);
					end else begin
						st_q <= ST_RX;
					end
				end
				ST_WAIT: begin
					if (t1_q == 17'h0_0000) begin
						st_q <= ST_SEND;
						start_q <= 1'b1;
					end else begin
						t1_q <= t1_q - 17'h0_0001;
					end
				end
				ST_SEND: begin
					if (tx_done) begin
						st_q <= ST_RX;
					end
				end
				default: st_q <= ST_RX;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pay_q <= '0;
			plen_q <= 4'h0;
			tx_high_rate_o <= 1'b0;
			tx_dual_sub_o <= 1'b0;
			lastcmd_q <= 8'h00;
		end else if ((st_q == ST_EVAL) && rsp_d) begin
			pay_q <= pay_d;
			plen_q <= plen_d;
			tx_high_rate_o <= fl[`FCH_FLG_RATE];
			tx_dual_sub_o <= fl[`FCH_FLG_SUB];
			lastcmd_q <= cmd;
		end
	end

	// initiated flag: only reset, standing in for power loss, clears it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			init_q <= 1'b0;
		end else if ((st_q == ST_EVAL) && seti_d) begin
			init_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slot_q <= 4'h0;
			live_q <= 1'b0;
		end else if (st_q == ST_EVAL) begin
			slot_q <= slot_use;
			live_q <= inv_ok_d && !fl[`FCH_FLG_ONE] &&
				(slot_use != 4'hF);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			crcerr_q <= 16'h0000;
		end else if ((st_q == ST_EVAL) && new_q && !crc_ok) begin
			crcerr_q <= crcerr_q + 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_fast_o <= 1'b0;
		end else if (start_q) begin
			tx_fast_o <= 1'b1;
		end else if (tx_done) begin
			tx_fast_o <= 1'b0;
		end
	end

	fch_tx u_tx (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(start_q),
		.len_i(plen_q),
		.data_i(pay_q),
		.tx_ready_i(tx_ready_i),
		.tx_valid_o(tx_valid_o),
		.tx_byte_o(tx_byte_o),
		.tx_last_o(tx_last_o),
		.tx_active_o(tx_active_o),
		.done_o(tx_done)
	);

	////////////////////////////////////////////////////////////////////
	// avalon-mm slave, one wait cycle per access
	logic we;
	logic [8:0] areg;
	logic [31:0] rd_d;

	function automatic logic [31:0] fch_merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = n[8*i +: 8];
			end
		end
		return r;
	endfunction : fch_merge

	assign we = avs_write_i && !avs_waitrequest_o;
	assign areg = {avs_address_i[8:2], 2'b00};

	always_comb begin
		rd_d = 32'h0000_0000;
		if (avs_address_i[`FCH_MEM_BIT]) begin
			rd_d = mem_q[avs_address_i[7:2]];
		end else begin
			case (areg)
				`FCH_REG_STATUS: rd_d = {crcerr_q, lastcmd_q, 6'h00,
					(st_q != ST_RX), init_q};
				`FCH_REG_UID_LO: rd_d = uid_q[31:0];
				`FCH_REG_UID_HI: rd_d = uid_q[63:32];
				`FCH_REG_LOCK_LO: rd_d = lock_q[31:0];
				`FCH_REG_LOCK_HI: rd_d = lock_q[63:32];
				`FCH_REG_CTRL: rd_d = {24'h00_0000, afi_q};
				default: rd_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_waitrequest_o && (avs_read_i || avs_write_i)) begin
			avs_waitrequest_o <= 1'b0;
			avs_readdata_o <= avs_read_i ? rd_d : 32'h0000_0000;
		end else begin
			avs_waitrequest_o <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			uid_q <= '0;
			lock_q <= '0;
			afi_q <= 8'h00;
		end else if (we && !avs_address_i[`FCH_MEM_BIT]) begin
			case (areg)
				`FCH_REG_UID_LO: uid_q[31:0] <= fch_merge(uid_q[31:0],
					avs_writedata_i, avs_byteenable_i);
				`FCH_REG_UID_HI: uid_q[63:32] <= fch_merge(uid_q[63:32],
					avs_writedata_i, avs_byteenable_i);
				`FCH_REG_LOCK_LO: lock_q[31:0] <= fch_merge(lock_q[31:0],
					avs_writedata_i, avs_byteenable_i);
				`FCH_REG_LOCK_HI: lock_q[63:32] <= fch_merge(lock_q[63:32],
					avs_writedata_i, avs_byteenable_i);
				`FCH_REG_CTRL: if (avs_byteenable_i[0]) begin
					afi_q <= avs_writedata_i[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < `FCH_NBLK_N; i++) begin
				mem_q[i] <= 32'h0000_0000;
			end
		end else if (we && avs_address_i[`FCH_MEM_BIT]) begin
			mem_q[avs_address_i[7:2]] <= fch_merge(mem_q[avs_address_i[7:2]],
				avs_writedata_i, avs_byteenable_i);
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	logic [16:0] t1_seen_q;

	always_ff @(posedge clk_i) begin
		if (rst_i || (st_q == ST_EVAL)) begin
			t1_seen_q <= 17'h0_0000;
		end else if (st_q == ST_WAIT) begin
			t1_seen_q <= t1_seen_q + 17'h0_0001;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_init_req;
		(st_q == ST_EVAL) && seti_d;
	endsequence
	sequence s_inv_cold;
		(st_q == ST_EVAL) && (cmd == `FCH_CMD_INV) && !init_q;
	endsequence

	a_init_silent: assert property (s_inv_cold |=> (st_q == ST_RX) ##1
		!start_q)
		else $error("inventory answered before initiate");
	a_crc_drop: assert property ((st_q == ST_EVAL) && new_q && !crc_ok
		&& !live_q |=> st_q == ST_RX)
		else $error("bad crc frame not dropped");
	a_inv_silent: assert property ((st_q == ST_EVAL) && (cmd ==
		`FCH_CMD_INV) && !inv_ok_d |=> st_q == ST_RX)
		else $error("faulty inventory produced a reply");
	a_t1_delay: assert property (start_q |-> t1_seen_q ==
		17'(T1_CYC))
		else $error("reply start not t1 after eof");
	a_t1_quiet: assert property ((st_q == ST_WAIT) |-> !tx_valid_o &&
		!tx_active_o)
		else $error("link driven during t1");
	a_init_set: assert property (s_init_req |=> init_q && (st_q ==
		ST_WAIT))
		else $error("initiate did not set flag or reply");
	a_init_hold: assert property (init_q |=> init_q)
		else $error("initiated flag lost without reset");
	a_init_mode: assert property (s_init_req |-> !fl[`FCH_FLG_SEL] &&
		!fl[`FCH_FLG_ADR])
		else $error("initiate accepted in addressed mode");
	a_fast_rate: assert property (tx_valid_o |-> tx_fast_o)
		else $error("response not at double rate");
	a_read_data: assert property ((st_q == ST_EVAL) && rd_ok_d |=>
		pay_q[(fl[`FCH_FLG_OPT] ? 16 : 8) +: 32] == $past(word_d))
		else $error("read payload differs from block");
	a_lock_byte: assert property ((st_q == ST_EVAL) && rd_ok_d &&
		fl[`FCH_FLG_OPT] |=> pay_q[15:8] == {7'h00, $past(lock_d)} &&
		plen_q == `FCH_PL_RD_LK)
		else $error("lock status byte wrong");
	a_err_addr: assert property ((st_q == ST_EVAL) && new_q && crc_ok &&
		(cmd == `FCH_CMD_READ) && rsp_d && !rd_ok_d |=> plen_q ==
		`FCH_PL_ERR && pay_q[7:0] == `FCH_RSP_ERR)
		else $error("read error reply malformed");
	a_uid_reply: assert property ((st_q == ST_EVAL) && rsp_d && (seti_d
		|| inv_ok_d) |=> pay_q[79:16] == uid_q && plen_q ==
		`FCH_PL_UID)
		else $error("uid reply malformed");
endmodule : fch_top

// [src/fch_map.svh]
// offsets, field positions, codes and timing figures of the fast command block
// assumes inclusion by bare name ahead of the package and modules
`ifndef FCH_MAP_SVH
`define FCH_MAP_SVH
`define FCH_CMD_READ 8'hC0
`define FCH_CMD_INV 8'hC1
`define FCH_CMD_INIT 8'hC2
`define FCH_FLG_SUB 0
`define FCH_FLG_RATE 1
`define FCH_FLG_INV 2
`define FCH_FLG_SEL 4
`define FCH_FLG_AFI 4
`define FCH_FLG_ADR 5
`define FCH_FLG_ONE 5
`define FCH_FLG_OPT 6
`define FCH_RSP_OK 8'h00
`define FCH_RSP_ERR 8'h01
`define FCH_DSFID 8'h00
`define FCH_ERR_GEN 8'h0F
`define FCH_ERR_ADDR 8'h10
`define FCH_CRC_INIT 16'hFFFF
`define FCH_CRC_POLY 16'h8408
`define FCH_CRC_RES 16'hF0B8
`define FCH_POS_FLG 4'h0
`define FCH_POS_CMD 4'h1
`define FCH_POS_MFG 4'h2
`define FCH_POS_UID 4'h3
`define FCH_POS_BLK 4'h3
`define FCH_POS_BLK_ADR 4'hB
`define FCH_POS_AFI 4'h3
`define FCH_POS_MLEN 4'h3
`define FCH_POS_MASK 4'h4
`define FCH_LEN_MIN 5'h05
`define FCH_LEN_RD 5'h06
`define FCH_LEN_RD_ADR 5'h0E
`define FCH_LEN_INV 5'h06
`define FCH_RXD 5'h10
`define FCH_RXD_N 16
`define FCH_NBLK 8'h40
`define FCH_NBLK_N 64
`define FCH_MASK_MAX 8'h40
`define FCH_PL_UID 4'hA
`define FCH_PL_ERR 4'h2
`define FCH_PL_RD 4'h5
`define FCH_PL_RD_LK 4'h6
`define FCH_REG_STATUS 9'h000
`define FCH_REG_UID_LO 9'h004
`define FCH_REG_UID_HI 9'h008
`define FCH_REG_LOCK_LO 9'h00C
`define FCH_REG_LOCK_HI 9'h010
`define FCH_REG_CTRL 9'h014
`define FCH_MEM_BIT 8
`define FCH_T1_NS 320940
`define FCH_CLK_MHZ 200
`endif

// [src/fch_pkg.sv]
// types shared by the fast command handler modules
// assumes fch_map.svh for all numeric figures
package fch_pkg;
	typedef enum logic [1:0] {ST_RX, ST_EVAL, ST_WAIT, ST_SEND} fch_state_t;
	typedef logic [7:0] fch_byte_t;
endpackage : fch_pkg

// [src/fch_crc.sv]
// byte-wide reflected crc16 accumulator, with combinational next value
// assumes one byte per enable, clear before each frame
`timescale 1ns/1ps
`include "fch_map.svh"
module fch_crc import fch_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic en_i,
	input wire fch_byte_t byte_i,
	output logic [15:0] crc_o,
	output logic [15:0] nxt_o
);
	function automatic logic [15:0] fch_step(input logic [15:0] c,
		input fch_byte_t b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `FCH_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : fch_step

	assign nxt_o = fch_step(crc_o, byte_i);

	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			crc_o <= `FCH_CRC_INIT;
		end else if (en_i) begin
			crc_o <= nxt_o;
		end
	end
endmodule : fch_crc

// [src/fch_tx.sv]
// response serializer: payload bytes lsb first, then inverted crc16
// assumes start only while idle; the link drains bytes with tx_ready_i
`timescale 1ns/1ps
`include "fch_map.svh"
module fch_tx import fch_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [3:0] len_i,
	input wire logic [79:0] data_i,
	input wire logic tx_ready_i,
	output logic tx_valid_o,
	output fch_byte_t tx_byte_o,
	output logic tx_last_o,
	output logic tx_active_o,
	output logic done_o
);
	logic [3:0] len_q;
	logic [3:0] idx_q;
	logic [79:0] data_q;
	logic [15:0] crc;
	logic [15:0] crc_nxt;
	logic hs;
	logic [3:0] nidx;
	logic [3:0] tot;

	assign hs = tx_valid_o && tx_ready_i;
	assign nidx = idx_q + 4'h1;
	assign tot = len_q + 4'h2;

	fch_crc u_crc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(start_i),
		.en_i(hs && (idx_q < len_q)),
		.byte_i(tx_byte_o),
		.crc_o(crc),
		.nxt_o(crc_nxt)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			len_q <= 4'h0;
			idx_q <= 4'h0;
			data_q <= '0;
			tx_valid_o <= 1'b0;
			tx_byte_o <= 8'h00;
			tx_last_o <= 1'b0;
			tx_active_o <= 1'b0;
			done_o <= 1'b0;
		end else if (start_i && !tx_active_o) begin
			len_q <= len_i;
			data_q <= data_i;
			idx_q <= 4'h0;
			tx_valid_o <= 1'b1;
			tx_byte_o <= data_i[7:0];
			tx_last_o <= 1'b0;
			tx_active_o <= 1'b1;
			done_o <= 1'b0;
		end else if (hs && (nidx == tot)) begin
			tx_valid_o <= 1'b0;
			tx_last_o <= 1'b0;
			tx_active_o <= 1'b0;
			done_o <= 1'b1;
		end else if (hs) begin
			idx_q <= nidx;
			tx_last_o <= (nidx == (tot - 4'h1));
			if (nidx < len_q) begin
				tx_byte_o <= data_q[{nidx, 3'b000} +: 8];
			end else if (nidx == len_q) begin
				tx_byte_o <= ~crc_nxt[7:0];
			end else begin
				tx_byte_o <= ~crc[15:8];
			end
		end else begin
			done_o <= 1'b0;
		end
	end
endmodule : fch_tx

// [sim/fch_rdr.sv]
// reader side model: drives request frames, takes reply bytes with stalls
// assumes the bench calls send() right after a rising clock edge
`timescale 1ns/1ps
module fch_rdr import fch_pkg::*; (
	input wire logic clk_i,
	input wire logic stall_i,
	input wire logic tx_valid_i,
	input wire fch_byte_t tx_byte_i,
	input wire logic tx_last_i,
	input wire logic tx_fast_i,
	output logic rx_sof_o,
	output logic rx_valid_o,
	output fch_byte_t rx_byte_o,
	output logic rx_eof_o,
	output logic tx_ready_o
);
	fch_byte_t rsp[$];
	int cyc = 0;
	int t_eof = 0;
	int t_first = -1;
	int n_last = 0;
	int n_slow = 0;
	initial begin
		rx_sof_o = 0;
		rx_valid_o = 0;
		rx_byte_o = 8'h00;
		rx_eof_o = 0;
		tx_ready_o = 1;
	end
	////////////////////////////////////////
	// reply capture, first byte timed from the latest eof, of a request or of a bare slot
	always @(posedge clk_i) begin
		if (rx_eof_o) t_eof = cyc;
		if (tx_valid_i && t_first < 0) t_first = cyc - t_eof;
		if (tx_valid_i && tx_ready_o) begin
			rsp.push_back(tx_byte_i);
			n_slow += !tx_fast_i;
			if (tx_last_i) n_last = rsp.size();
		end
		tx_ready_o <= !stall_i;
		cyc++;
	end
	// released data line shows the inverse of the last byte
	task automatic send(input fch_byte_t q[$]);
		rsp = {};
		t_first = -1;
		n_last = 0;
		n_slow = 0;
		rx_sof_o <= 1;
		@(posedge clk_i);
		rx_sof_o <= 0;
		foreach (q[i]) begin
			rx_valid_o <= 1;
			rx_byte_o <= q[i];
			@(posedge clk_i);
			rx_valid_o <= 0;
			rx_byte_o <= ~q[i];
			@(posedge clk_i);
		end
		rx_eof_o <= 1;
		@(posedge clk_i);
		rx_eof_o <= 0;
	endtask : send
	// bare eof after the reader's t3 wait moves to the next slot
	task automatic slot(input int t3);
		repeat (t3) @(posedge clk_i);
		rx_eof_o <= 1;
		@(posedge clk_i);
		rx_eof_o <= 0;
	endtask : slot
endmodule : fch_rdr

// [sim/tb_fch_top.sv]
// self-checking bench of the fast command handler
// assumes fch_rdr as the reader and a 200 MHz clock
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
	n_errors++; $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module tb_fch_top import fch_pkg::*; ;
	localparam int T1 = 8;
	// reader's t3: beyond the t1 reply start plus sof, scaled
	localparam int T3 = T1 + 16;
	// arbitrary maker code
	localparam logic [7:0] MFG = 8'h5A;
	logic clk_i = 0;
	logic rst_i = 1;
	logic rx_sof_i, rx_valid_i, rx_eof_i, tx_ready_i;
	fch_byte_t rx_byte_i, tx_byte_o;
	logic tx_valid_o, tx_last_o, tx_active_o, tx_fast_o;
	logic tx_high_rate_o, tx_dual_sub_o, avs_waitrequest_o;
	logic [8:0] avs_address_i = 9'h000;
	logic avs_read_i = 0;
	logic avs_write_i = 0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [31:0] avs_readdata_o, rd;
	logic [15:0] lf_q = 16'h0035;
	logic stall_q = 0;
	logic [63:0] uid;
	logic [31:0] mem [64];
	fch_byte_t q[$];
	fch_byte_t e[$];
	int n_errors = 0;
	int checked = 0;
	always #2.5 clk_i = ~clk_i;
	fch_top #(.MFG_CODE(MFG), .T1_CYC(T1)) fch_top_i (.clk_i, .rst_i,
		.rx_sof_i, .rx_valid_i, .rx_byte_i, .rx_eof_i, .tx_ready_i,
		.tx_valid_o, .tx_byte_o, .tx_last_o, .tx_active_o, .tx_fast_o,
		.tx_high_rate_o, .tx_dual_sub_o, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i,
		.avs_readdata_o, .avs_waitrequest_o);
	fch_rdr fch_rdr_i (.clk_i(clk_i), .stall_i(stall_q),
		.tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o),
		.tx_last_i(tx_last_o), .tx_fast_i(tx_fast_o),
		.rx_sof_o(rx_sof_i), .rx_valid_o(rx_valid_i),
		.rx_byte_o(rx_byte_i), .rx_eof_o(rx_eof_i),
		.tx_ready_o(tx_ready_i));
	////////////////////////////////////////
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nxt
	always @(posedge clk_i) begin
		lf_q <= nxt(lf_q);
		stall_q <= lf_q[0] & lf_q[3];
	end
	// appends the complemented crc, low byte first
	function automatic void add_crc(ref fch_byte_t b[$]);
		logic [15:0] c = 16'hFFFF;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
		end
		b.push_back(~c[7:0]);
		b.push_back(~c[15:8]);
	endfunction : add_crc
	task automatic push(ref fch_byte_t b[$], input logic [31:0] w);
		for (int i = 0; i < 4; i++) b.push_back(w[8*i+:8]);
	endtask : push
	task automatic bus(input logic w, input logic [8:0] a,
		input logic [31:0] d);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		avs_write_i <= 0;
		avs_read_i <= 0;
		@(posedge clk_i);
	endtask : bus
	// sends q, expects reply e (empty means silence)
	task automatic xfer(input bit bad, input int ns = 0);
		int k;
		fch_byte_t r[$];
		fch_byte_t x[$];
		r = q;
		x = e;
		add_crc(r);
		if (bad) r[r.size() - 1] ^= 8'h01;
		if (x.size() > 0) add_crc(x);
		fch_rdr_i.send(r);
		repeat (ns) fch_rdr_i.slot(T3);
		for (k = 0; k < T1 + 120; k++) begin
			@(posedge clk_i);
			if (x.size() > 0 && fch_rdr_i.n_last > 0) break;
		end
		repeat (3) @(posedge clk_i);
		`CHK("len", x.size(), fch_rdr_i.rsp.size())
		`CHK("active", 1'b0, tx_active_o)
		foreach (x[i]) if (i < fch_rdr_i.rsp.size())
			`CHK("byte", x[i], fch_rdr_i.rsp[i])
		if (x.size() > 0) begin
			`CHK("t1", T1 + 3, fch_rdr_i.t_first)
			`CHK("last", x.size(), fch_rdr_i.n_last)
			`CHK("slow", 0, fch_rdr_i.n_slow)
			`CHK("rate", q[0][1], tx_high_rate_o)
			`CHK("sub", q[0][0], tx_dual_sub_o)
		end
	endtask : xfer
	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#300000;
		n_errors++;
		give_verdict();
	end
	////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		uid = {lf_q, ~lf_q, nxt(lf_q), 16'h3C5A};
		bus(0, 9'h004, 0);
		`CHK("uid_lo", 32'h0000_0000, rd)
		bus(1, 9'h004, uid[31:0]);
		bus(1, 9'h008, uid[63:32]);
		bus(1, 9'h00C, 32'h0000_0008);
		bus(1, 9'h018, 32'h0000_FFFF);
		bus(0, 9'h018, 0);
		`CHK("unmapped", 32'h0000_0000, rd)
		for (int n = 0; n < 64; n++) begin
			mem[n] = {lf_q, ~lf_q};
			bus(1, 9'h100 + 9'(4 * n), mem[n]);
		end
		avs_byteenable_i <= 4'h2;
		bus(1, 9'h11C, 32'hFFFF_FFFF);
		avs_byteenable_i <= 4'hF;
		mem[7][15:8] = 8'hFF;
		bus(0, 9'h11C, 0);
		`CHK("blk7", mem[7], rd)
		q = {8'h24, 8'hC1, MFG, 8'h00};
		e = {};
		xfer(0);
		q = {8'h12, 8'hC2, MFG};
		xfer(0);
		q = {8'h02, 8'hC2, MFG};
		xfer(1);
		bus(0, 9'h000, 0);
		`CHK("init_flag", 1'b0, rd[0])
		`CHK("crc_err", 16'h0001, rd[31:16])
		e = {8'h00, 8'h00};
		push(e, uid[31:0]);
		push(e, uid[63:32]);
		xfer(0);
		bus(0, 9'h000, 0);
		`CHK("init_flag", 1'b1, rd[0])
		`CHK("last_cmd", 8'hC2, rd[15:8])
		q = {8'h24, 8'hC1, MFG, 8'h08, uid[7:0]};
		xfer(0);
		q = {8'h04, 8'hC1, MFG, 8'h00};
		xfer(0, uid[3:0]);
		bus(1, 9'h014, 32'h0000_00A7);
		q = {8'h34, 8'hC1, MFG, 8'hA7, 8'h00};
		xfer(0);
		q = {8'h34, 8'hC1, MFG, 8'hA6, 8'h00};
		e = {};
		xfer(0);
		q = {8'h24, 8'hC1, MFG, 8'h41};
		e = {};
		xfer(0);
		q = {8'h42, 8'hC0, MFG, 8'h03};
		e = {8'h00, 8'h01};
		push(e, mem[3]);
		xfer(0);
		q = {8'h62, 8'hC0, MFG};
		push(q, uid[31:0]);
		push(q, uid[63:32]);
		q.push_back(8'h05);
		e = {8'h00, 8'h00};
		push(e, mem[5]);
		xfer(0);
		q = {8'h02, 8'hC0, MFG, 8'h40};
		e = {8'h01, 8'h10};
		xfer(0);
		q = {8'h06, 8'hC0, MFG, 8'h01};
		e = {8'h01, 8'h0F};
		xfer(0);
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		bus(0, 9'h000, 0);
		`CHK("init_flag", 1'b0, rd[0])
		q = {8'h24, 8'hC1, MFG, 8'h00};
		e = {};
		xfer(0);
		give_verdict();
	end
endmodule : tb_fch_top
